// ==== design/ref_out_divider.v ====
// divider producing the second reference clock output
`timescale 1ns/1ps
`include "synth_ctrl_consts.vh"
module ref_out_divider (
  input wire core_clk,
  input wire sys_rst,
  input wire ref_tick,
  input wire [1:0] mode,
  output reg ref_clock_out_c
);
  reg count;
  // tick parity; divide-by-1 follows the tick itself
  always @(posedge core_clk) begin
    if (sys_rst) begin
      count <= 1'b0;
      ref_clock_out_c <= 1'b0;
    end else begin
      if (ref_tick) begin
        count <= ~count;
      end
      case (mode)
        `DIVC_OFF: ref_clock_out_c <= 1'b0;
        `DIVC_BY1: ref_clock_out_c <= ref_tick;
        `DIVC_BY2: begin
          if (ref_tick) begin
            ref_clock_out_c <= ~ref_clock_out_c;
          end
        end
        `DIVC_BY4: begin
          if (ref_tick && count) begin
            ref_clock_out_c <= ~ref_clock_out_c;
          end
        end
        default: ref_clock_out_c <= 1'b0;
      endcase
    end
  end
endmodule // ref_out_divider

// ==== design/synth_ctrl_consts.vh ====
// register offsets, field positions, reset values for synth control
`ifndef SYNTH_CTRL_CONSTS_VH
`define SYNTH_CTRL_CONSTS_VH
`define OVR_ADDR 8'h58
`define TRIM_ADDR 8'h59
`define RESET_ADDR 8'h5C
`define OVR_RESET 8'h00
`define TRIM_RESET 7'h00
`define RESET_RESET 1'h0
`define OVR_EN_BIT 7
`define DIVC_HI 3
`define DIVC_LO 2
`define SE_BIT 1
`define EN_BIT 0
`define RST_BIT 0
`define DIVC_OFF 2'h0
`define DIVC_BY1 2'h1
`define DIVC_BY2 2'h2
`define DIVC_BY4 2'h3
`endif

// ==== design/synth_override_trim_ctrl.v ====
// synthesizer strap override, oscillator trim and cal reset registers
//
// How it works
// - override bit picks straps or register fields
// - override drives output C from bits 3:2
// - divider codes: off, /1, /2, /4
// - without override, config straps set output C
// - override bit 1 selects single-ended reference
// - override bit 0 enables the synthesizer
// - seven-bit trim, reset zero, calibration writes it
// - trim readable after calibration, software may restore
// - reset falling starts calibration when enabled
// - done reads one, or immediately if skipped
`timescale 1ns/1ps
`include "synth_ctrl_consts.vh"
module synth_override_trim_ctrl (
  input wire core_clk,
  input wire sys_rst,
  input wire cfg_wr,
  input wire cfg_rd,
  input wire [7:0] cfg_addr,
  input wire [7:0] cfg_wdata,
  output reg [7:0] cfg_rdata,
  input wire synth_enable_strap,
  input wire single_ended_ref_strap,
  input wire clock_config_strap_0,
  input wire clock_config_strap_1,
  input wire cal_enable,
  input wire cal_busy,
  input wire cal_trim_we,
  input wire [6:0] cal_trim_value,
  input wire ref_tick,
  output reg synth_enable,
  output reg single_ended_ref_select,
  output reg synth_cal_reset_bit,
  output reg cal_start,
  output reg cal_done,
  output wire ref_clock_out_c
);
  reg [7:0] synth_override_control;
  reg [6:0] oscillator_freq_trim;
  reg [1:0] strap_meta;
  reg [1:0] strap_sync;
  reg [1:0] cfg_meta;
  reg [1:0] cfg_sync;
  reg cal_running;
  reg [1:0] next_divc;
  wire synth_pin_override_enable;
  wire [1:0] ref_out_c_divider_select;
  wire single_ended_ref_select_value;
  wire synth_enable_value;
  wire wr_ovr;
  wire wr_trim;
  wire wr_reset;
  wire reset_set;
  wire reset_clear;
  wire cal_finish;

  // one address compare, shared by every write decode
  function addr_hit;
    input [7:0] addr;
    input [7:0] target;
    begin
      addr_hit = (addr == target);
    end
  endfunction

  // override fields, named as the synth sees them
  assign synth_pin_override_enable = synth_override_control[`OVR_EN_BIT];
  assign ref_out_c_divider_select =
    synth_override_control[`DIVC_HI:`DIVC_LO];
  assign single_ended_ref_select_value = synth_override_control[`SE_BIT];
  assign synth_enable_value = synth_override_control[`EN_BIT];

  // one write strobe per register
  assign wr_ovr = cfg_wr && addr_hit(cfg_addr, `OVR_ADDR);
  assign wr_trim = cfg_wr && addr_hit(cfg_addr, `TRIM_ADDR);
  assign wr_reset = cfg_wr && addr_hit(cfg_addr, `RESET_ADDR);
  // launch needs a real 1 to 0 step; a repeated 0 write stays idle
  assign reset_set = wr_reset && cfg_wdata[`RST_BIT];
  assign reset_clear = wr_reset && !cfg_wdata[`RST_BIT] &&
    synth_cal_reset_bit;
  // engine must raise busy by the cycle after the launch pulse
  assign cal_finish = cal_running && !cal_busy &&
    !cal_start;

  // enable and single-ended straps are pins: two flops before use
  always @(posedge core_clk) begin
    if (sys_rst) begin
      strap_meta <= 2'h0;
      strap_sync <= 2'h0;
    end else begin
      strap_meta <= {synth_enable_strap, single_ended_ref_strap};
      strap_sync <= strap_meta;
    end
  end

  // bits may land a cycle apart; straps are static, so this is benign
  always @(posedge core_clk) begin
    if (sys_rst) begin
      cfg_meta <= 2'h0;
      cfg_sync <= 2'h0;
    end else begin
      cfg_meta <= {clock_config_strap_1, clock_config_strap_0};
      cfg_sync <= cfg_meta;
    end
  end

  // override register keeps all eight bits as written
  always @(posedge core_clk) begin
    if (sys_rst) begin
      synth_override_control <= `OVR_RESET;
    end else if (wr_ovr) begin
      synth_override_control <= cfg_wdata;
    end
  end

  // synth reset bit brackets reprogramming by software
  always @(posedge core_clk) begin
    if (sys_rst) begin
      synth_cal_reset_bit <= `RESET_RESET;
    end else if (wr_reset) begin
      synth_cal_reset_bit <= cfg_wdata[`RST_BIT];
    end
  end

  // trim word; engine write wins a clash, software mid-cal is misuse
  always @(posedge core_clk) begin
    if (sys_rst) begin
      oscillator_freq_trim <= `TRIM_RESET;
    end else if (cal_trim_we) begin
      oscillator_freq_trim <= cal_trim_value;
    end else if (wr_trim) begin
      oscillator_freq_trim <= cfg_wdata[6:0];
    end
  end

  // launch pulse, one cycle, only when calibration is enabled
  always @(posedge core_clk) begin
    if (sys_rst) begin
      cal_start <= 1'b0;
    end else begin
      cal_start <= reset_clear && cal_enable;
    end
  end

  // running flag; a reset write aborts a calibration in flight
  always @(posedge core_clk) begin
    if (sys_rst) begin
      cal_running <= 1'b0;
    end else if (reset_set) begin
      cal_running <= 1'b0;
    end else if (reset_clear) begin
      cal_running <= cal_enable;
    end else if (cal_finish) begin
      cal_running <= 1'b0;
    end
  end

  // done flag; the abort beats completion, as the run is cancelled
  always @(posedge core_clk) begin
    if (sys_rst) begin
      cal_done <= 1'b0;
    end else if (reset_set) begin
      cal_done <= 1'b0;
    end else if (reset_clear) begin
      cal_done <= !cal_enable;
    end else if (cal_finish) begin
      cal_done <= 1'b1;
    end
  end

  // source selection; fields reach the synth only under override
  always @* begin
    if (synth_pin_override_enable) begin
      next_divc = ref_out_c_divider_select;
    end else begin
      next_divc = cfg_sync;
    end
  end

  // enable output: override value or synced strap
  always @(posedge core_clk) begin
    if (sys_rst) begin
      synth_enable <= 1'b0;
    end else if (synth_pin_override_enable) begin
      synth_enable <= synth_enable_value;
    end else begin
      synth_enable <= strap_sync[1];
    end
  end

  // single-ended select: override value or synced strap
  always @(posedge core_clk) begin
    if (sys_rst) begin
      single_ended_ref_select <= 1'b0;
    end else if (synth_pin_override_enable) begin
      single_ended_ref_select <= single_ended_ref_select_value;
    end else begin
      single_ended_ref_select <= strap_sync[0];
    end
  end

  // read data registered; unmapped addresses read zero
  always @(posedge core_clk) begin
    if (sys_rst) begin
      cfg_rdata <= 8'h00;
    end else if (cfg_rd) begin
      case (cfg_addr)
        `OVR_ADDR: cfg_rdata <= synth_override_control;
        `TRIM_ADDR: cfg_rdata <= {1'b0, oscillator_freq_trim};
        `RESET_ADDR: cfg_rdata <= {7'h00, synth_cal_reset_bit};
        default: cfg_rdata <= 8'h00;
      endcase
    end
  end

  ref_out_divider u_div (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .ref_tick(ref_tick),
    .mode(next_divc),
    .ref_clock_out_c(ref_clock_out_c)
  );
endmodule // synth_override_trim_ctrl

// ==== testbench/synth_ctrl_asserts.sv ====
// checker for the synth control block
`timescale 1ns/1ps
module synth_ctrl_asserts (
  input wire core_clk,
  input wire sys_rst,
  input wire cfg_wr,
  input wire cfg_rd,
  input wire cal_enable,
  input wire [7:0] cfg_addr,
  input wire [7:0] cfg_wdata,
  input wire [7:0] cfg_rdata,
  input wire synth_enable,
  input wire single_ended_ref_select,
  input wire synth_cal_reset_bit,
  input wire cal_start,
  input wire cal_done
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // writes to the reset and override registers
  wire rw = cfg_wr && cfg_addr == 8'h5C;
  wire go = rw && !cfg_wdata[0] && synth_cal_reset_bit;
  wire ow = cfg_wr && cfg_addr == 8'h58 && cfg_wdata[7];
  a_cal_go: assert property (go && cal_enable |=> cal_start)
    else $error("no start");
  a_go_once: assert property (cal_start |=> !cal_start)
    else $error("long start");
  a_skip_done: assert property (go && !cal_enable |=> cal_done)
    else $error("no done");
  a_rst_set: assert property (rw && cfg_wdata[0]
    |=> synth_cal_reset_bit && !cal_done) else $error("bad reset");
  // field lands in the register, then in the output flop
  a_ovr_en: assert property (ow && cfg_wdata[0]
    |-> ##2 synth_enable) else $error("no enable");
  a_ovr_off: assert property (ow && !cfg_wdata[0]
    |-> ##2 !synth_enable) else $error("stuck enable");
  a_ovr_se: assert property (ow && cfg_wdata[1]
    |-> ##2 single_ended_ref_select) else $error("no se");
  a_ovr_se_off: assert property (ow && !cfg_wdata[1]
    |-> ##2 !single_ended_ref_select) else $error("stuck se");
  a_trim_top: assert property (cfg_rd && cfg_addr == 8'h59
    |=> !cfg_rdata[7]) else $error("trim bit 7");
  a_start_cause: assert property (cal_start
    |-> $past(go && cal_enable)) else $error("stray start");
endmodule // synth_ctrl_asserts

bind synth_override_trim_ctrl synth_ctrl_asserts chk (.*);

// ==== testbench/testbench.sv ====
// self-checking bench for the synth control block
`timescale 1ns/1ps
module testbench;
  reg core_clk = 1'h0, sys_rst = 1'h1, cfg_wr = 1'h0, cfg_rd = 1'h0;
  reg cal_enable = 1'h0, cal_busy = 1'h0, cal_trim_we = 1'h0;
  reg ref_tick = 1'h0, synth_enable_strap = 1'h0;
  reg single_ended_ref_strap = 1'h1, clock_config_strap_0 = 1'h0;
  reg clock_config_strap_1 = 1'h0;
  reg [7:0] cfg_addr = 8'h00, cfg_wdata = 8'h00;
  reg [6:0] cal_trim_value = 7'h00;
  wire [7:0] cfg_rdata;
  wire synth_enable, single_ended_ref_select, synth_cal_reset_bit;
  wire cal_start, cal_done, ref_clock_out_c;
  // done, out c, reset bit, se select, enable in one byte
  wire [7:0] st = {3'h0, cal_done, ref_clock_out_c, synth_cal_reset_bit,
    single_ended_ref_select, synth_enable};
  integer n_mismatch = 0, checks_done = 0;
  // edges of output c and launch pulses, plus a snapshot
  reg [7:0] n_edges = 8'h00, n_starts = 8'h00, e0 = 8'h00;
  reg out_c_prev = 1'h0;
  synth_override_trim_ctrl uut (.*);
  // 40 ns clock; reference tick every other cycle
  initial forever #20 core_clk = ~core_clk;
  always @(posedge core_clk) ref_tick <= ~ref_tick;
  // count rises of output c and launch pulses while they stand
  always @(posedge core_clk) begin
    out_c_prev <= ref_clock_out_c;
    if (ref_clock_out_c && !out_c_prev) n_edges <= n_edges + 8'h01;
    if (cal_start) n_starts <= n_starts + 8'h01;
  end
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) n_mismatch = n_mismatch + 1;
      if (got !== exp) $display("mismatch %0t got %h", $time, got);
    end
  endtask
  // one access; a read compares with d, then outputs with s
  task acc(input w, input [7:0] a, input [7:0] d, input [7:0] s);
    begin
      @(posedge core_clk);
      cfg_wr <= w;
      cfg_rd <= !w;
      cfg_addr <= a;
      cfg_wdata <= d;
      @(posedge core_clk);
      cfg_wr <= 1'h0;
      cfg_rd <= 1'h0;
      repeat (2) @(negedge core_clk);
      if (!w) chk(cfg_rdata, d);
      chk(st, s);
    end
  endtask
  // write the override byte, let output c settle, count rises over 16
  // cycles; the tick comes every other cycle, so 8 reference periods
  task div_chk(input [7:0] d, input [7:0] n);
    begin
      @(posedge core_clk);
      cfg_wr <= 1'h1;
      cfg_addr <= 8'h58;
      cfg_wdata <= d;
      @(posedge core_clk);
      cfg_wr <= 1'h0;
      repeat (8) @(posedge core_clk);
      e0 = n_edges;
      repeat (16) @(posedge core_clk);
      chk(n_edges - e0, n);
    end
  endtask
  // skipped cal first so done is known, then override, divider, cal
  initial begin
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'h0;
    acc(1'h1, 8'h5C, 8'h01, 8'h06);
    acc(1'h1, 8'h5C, 8'h00, 8'h12);
    acc(1'h0, 8'h59, 8'h00, 8'h12);
    acc(1'h1, 8'h58, 8'h81, 8'h11);
    acc(1'h1, 8'h58, 8'h03, 8'h12);
    $display("test registers done");
    div_chk(8'h84, 8'h08);
    div_chk(8'h88, 8'h04);
    div_chk(8'h8C, 8'h02);
    @(posedge core_clk);
    clock_config_strap_1 <= 1'h1;
    div_chk(8'h0C, 8'h04);
    @(posedge core_clk);
    clock_config_strap_0 <= 1'h1;
    div_chk(8'h04, 8'h02);
    acc(1'h1, 8'h58, 8'h82, 8'h12);
    acc(1'h0, 8'h58, 8'h82, 8'h12);
    $display("test divider done");
    @(posedge core_clk);
    cal_trim_we <= 1'h1;
    cal_trim_value <= 7'h2A;
    @(posedge core_clk);
    cal_trim_we <= 1'h0;
    acc(1'h0, 8'h59, 8'h2A, 8'h12);
    @(posedge core_clk);
    cal_enable <= 1'h1;
    cal_busy <= 1'h1;
    acc(1'h1, 8'h5C, 8'h01, 8'h06);
    acc(1'h1, 8'h5C, 8'h00, 8'h02);
    @(posedge core_clk);
    cal_busy <= 1'h0;
    repeat (2) @(negedge core_clk);
    chk(st, 8'h12);
    acc(1'h0, 8'h59, 8'h2A, 8'h12);
    chk(n_starts, 8'h01);
    $display("test calibration done");
    finish_test;
  end
  // hang guard; the sequence needs about 200 cycles
  initial begin
    #40000;
    n_mismatch = n_mismatch + 1;
    finish_test;
  end
endmodule // testbench
